/* File: rtl/sdram_cmd_fsm.sv */
// Behaviour
// - clock enable falling mid-burst enters suspend
// - suspend freezes state until clock enable rises
// - idle no-op stays, or powers down
// - read no-op lets burst finish, row active
// - read halt ends burst, row stays open
// - read during read restarts at new column
// - write during read starts write burst
// - close during read interrupts then precharges
// - write no-op finishes, then write recovery
// - write halt ends write, row active
// - read during write starts read burst
// - write during write restarts at column
// - close during write interrupts then precharges
// - read autoclose: only no-ops, then precharge
// - refresh with clock enable falling self-renews
// - self-renewal exits on rise with no-op
// - low power exits when clock enable rises
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// event buffer
// ------------------------------------------------------------
module sdram_evt_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  // the output word sits in a register so the top drives from flops
  assign in_ready = (cnt_r != CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (cnt_r != '0) && (!out_valid || out_ready);

  // storage array
  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push)
        wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
      if (pop)
        rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
      if (push && !pop)
        cnt_r <= CW'(cnt_r + 1'b1);
      else if (pop && !push)
        cnt_r <= CW'(cnt_r - 1'b1);
    end
  end

  // output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // sdram_evt_fifo

// ------------------------------------------------------------
// command state machine
// ------------------------------------------------------------
module sdram_cmd_fsm
  import sdram_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic EVT_READY,
  output logic EVT_VALID,
  output evt_s EVT_DATA,
  output st_e STATE,
  output logic [1:0] OPEN_BANKS,
  output logic SUSPENDED,
  output logic ILLEGAL_CMD,
  output logic [COL_W-1:0] COLUMN,
  output logic BURST_BANK,
  output logic [MODE_W-1:0] MODE_WORD,
  output logic [ROW_W-1:0] RENEW_ROW,
  output logic HOLD
);
  logic rst_meta_r;
  logic rst_n;
  logic cke_prev_r;
  st_e st_r, st_nxt;
  logic [1:0] banks_r, banks_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] tick_r, tick_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic bank_r, bank_nxt;
  logic ap_r, ap_nxt;
  logic susp_r, susp_nxt;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic ill_nxt;
  logic evt_v;
  evt_s evt_d;
  logic fifo_ready;
  logic hold;
  cmd_e cmd;
  logic cke_fall, cke_rise, quiet, done, bsel, aflag;
  logic go_fetch, go_store, go_close;

  // burst length code to beats minus one
  function automatic logic [CNT_W-1:0] last_beat(input logic [2:0] code);
    unique case (code)
      3'h1: return 16'h0001;
      3'h2: return 16'h0003;
      3'h3: return 16'h0007;
      3'h7: return 16'h00ff;
      default: return 16'h0000;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // command and clock enable edges
  assign cmd = decode(CS_N, RAS_N, CAS_N, WE_N);
  assign bsel = ADDR[BANK_SELECT_BIT];
  assign aflag = ADDR[AUTOCLOSE_FLAG_BIT];
  assign cke_fall = cke_prev_r && !CKE;
  assign cke_rise = !cke_prev_r && CKE;
  assign quiet = (cmd == CMD_UNSELECTED) || (cmd == CMD_IDLE);
  assign done = (cnt_r == '0);
  assign hold = !fifo_ready;

  // next state
  always_comb begin
    st_nxt = st_r;
    banks_nxt = banks_r;
    cnt_nxt = cnt_r;
    tick_nxt = tick_r;
    col_nxt = col_r;
    bank_nxt = bank_r;
    ap_nxt = ap_r;
    susp_nxt = susp_r;
    mode_nxt = mode_r;
    row_nxt = row_r;
    ill_nxt = 1'b0;
    evt_v = 1'b0;
    evt_d = '{kind: cmd, bank: bsel, col: ADDR[COL_W-1:0]};
    go_fetch = 1'b0;
    go_store = 1'b0;
    go_close = 1'b0;
    if (hold) begin
      st_nxt = st_r; // buffer full: everything waits
    end else if (susp_r) begin
      if (cke_rise)
        susp_nxt = 1'b0;
    end else if (st_r == ST_SELF_RENEW) begin
      if (cke_rise && quiet) begin
        st_nxt = ST_REFRESH;
        cnt_nxt = CNT_W'(ROW_CYCLE_CYC - 1);
      end else if (tick_r == '0) begin
        tick_nxt = CNT_W'(RENEW_TICK_CYC - 1);
        row_nxt = ROW_W'(row_r + 1'b1);
      end else begin
        tick_nxt = CNT_W'(tick_r - 1'b1);
      end
    end else if (st_r == ST_LOW_POWER) begin
      if (cke_rise)
        st_nxt = ST_IDLE;
    end else if (cke_fall && st_r != ST_IDLE) begin
      susp_nxt = 1'b1;
    end else if (cke_prev_r) begin
      evt_v = !quiet;
      if (!done)
        cnt_nxt = CNT_W'(cnt_r - 1'b1);
      unique case (st_r)
        ST_IDLE: begin
          unique case (cmd)
            CMD_UNSELECTED, CMD_IDLE, CMD_HALT:
              if (cke_fall) st_nxt = ST_LOW_POWER;
            CMD_ROW_OPEN: begin
              banks_nxt[bsel] = 1'b1;
              st_nxt = ST_ROW_ACTIVE;
            end
            CMD_RENEW: begin
              if (cke_fall) begin
                st_nxt = ST_SELF_RENEW;
                tick_nxt = CNT_W'(RENEW_TICK_CYC - 1);
              end else begin
                st_nxt = ST_REFRESH;
                cnt_nxt = CNT_W'(ROW_CYCLE_CYC - 1);
                row_nxt = ROW_W'(row_r + 1'b1);
              end
            end
            CMD_MODE_LOAD: mode_nxt = ADDR[MODE_W-1:0];
            CMD_CLOSE: ;
            default: ill_nxt = 1'b1;
          endcase
        end
        ST_ROW_ACTIVE: begin
          unique case (cmd)
            CMD_FETCH: go_fetch = 1'b1;
            CMD_STORE: go_store = 1'b1;
            CMD_CLOSE: go_close = 1'b1;
            CMD_UNSELECTED, CMD_IDLE, CMD_HALT: ;
            default: ill_nxt = 1'b1;
          endcase
        end
        ST_READ, ST_WRITE: begin
          unique case (cmd)
            CMD_UNSELECTED, CMD_IDLE: begin
              if (done && st_r == ST_READ)
                st_nxt = ST_ROW_ACTIVE;
              else if (done) begin
                st_nxt = ST_WRITE_REC;
                cnt_nxt = CNT_W'(WRITE_REC_CYC - 1);
              end
            end
            CMD_HALT: st_nxt = ST_ROW_ACTIVE;
            CMD_FETCH: go_fetch = 1'b1;
            CMD_STORE: go_store = 1'b1;
            CMD_CLOSE: go_close = 1'b1;
            default: ill_nxt = 1'b1;
          endcase
        end
        ST_READ_AC: begin
          if (!quiet)
            ill_nxt = 1'b1;
          else if (done) begin
            banks_nxt[bank_r] = 1'b0;
            st_nxt = ST_PRECHARGE;
            cnt_nxt = CNT_W'(PRECHARGE_CYC - 1);
          end
        end
        ST_WRITE_REC: begin
          unique case (cmd)
            CMD_FETCH: go_fetch = 1'b1;
            CMD_STORE: go_store = 1'b1;
            CMD_UNSELECTED, CMD_IDLE, CMD_HALT: begin
              if (done && ap_r) begin
                banks_nxt[bank_r] = 1'b0;
                st_nxt = ST_PRECHARGE;
                cnt_nxt = CNT_W'(PRECHARGE_CYC - 1);
              end else if (done) begin
                st_nxt = ST_ROW_ACTIVE;
              end
            end
            default: ill_nxt = 1'b1;
          endcase
        end
        ST_PRECHARGE, ST_REFRESH: begin
          if (!(quiet || cmd == CMD_HALT ||
                (cmd == CMD_CLOSE && st_r == ST_PRECHARGE)))
            ill_nxt = 1'b1;
          else if (done)
            st_nxt = (banks_r == 2'h0) ? ST_IDLE : ST_ROW_ACTIVE;
        end
        default: st_nxt = ST_IDLE;
      endcase
      if (ill_nxt)
        evt_v = 1'b0; // illegal commands leave no event
      // shared burst starts and closes
      if (go_fetch) begin
        st_nxt = aflag ? ST_READ_AC : ST_READ;
        cnt_nxt = last_beat(mode_r[2:0]);
        col_nxt = ADDR[COL_W-1:0];
        bank_nxt = bsel;
      end
      if (go_store) begin
        st_nxt = ST_WRITE;
        ap_nxt = aflag;
        cnt_nxt = last_beat(mode_r[2:0]);
        col_nxt = ADDR[COL_W-1:0];
        bank_nxt = bsel;
      end
      if (go_close) begin
        if (aflag)
          banks_nxt = 2'h0;
        else
          banks_nxt[bsel] = 1'b0;
        st_nxt = ST_PRECHARGE;
        cnt_nxt = CNT_W'(PRECHARGE_CYC - 1);
      end
    end
  end

  // clock enable history
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n)
      cke_prev_r <= 1'b0;
    else if (!hold)
      cke_prev_r <= CKE;
  end

  // main state and bank bookkeeping
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      banks_r <= 2'h0;
      cnt_r <= '0;
      tick_r <= '0;
      col_r <= '0;
      bank_r <= 1'b0;
      ap_r <= 1'b0;
      susp_r <= 1'b0;
      mode_r <= MODE_RESET;
      row_r <= '0;
    end else begin
      st_r <= st_nxt;
      banks_r <= banks_nxt;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      col_r <= col_nxt;
      bank_r <= bank_nxt;
      ap_r <= ap_nxt;
      susp_r <= susp_nxt;
      mode_r <= mode_nxt;
      row_r <= row_nxt;
    end
  end

  // registered status outputs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      STATE <= ST_IDLE;
      OPEN_BANKS <= 2'h0;
      SUSPENDED <= 1'b0;
      ILLEGAL_CMD <= 1'b0;
      COLUMN <= '0;
      BURST_BANK <= 1'b0;
      MODE_WORD <= MODE_RESET;
      RENEW_ROW <= '0;
      HOLD <= 1'b0;
    end else begin
      STATE <= st_nxt;
      OPEN_BANKS <= banks_nxt;
      SUSPENDED <= susp_nxt;
      ILLEGAL_CMD <= ill_nxt;
      COLUMN <= col_nxt;
      BURST_BANK <= bank_nxt;
      MODE_WORD <= mode_nxt;
      RENEW_ROW <= row_nxt;
      HOLD <= hold;
    end
  end

  // accepted commands leave through the buffer
  sdram_evt_fifo #(
    .WIDTH($bits(evt_s)),
    .DEPTH(EVT_DEPTH)
  ) u_evt_fifo (
    .clk(CLK),
    .rst_n(rst_n),
    .in_valid(evt_v),
    .in_ready(fifo_ready),
    .in_data(evt_d),
    .out_valid(EVT_VALID),
    .out_ready(EVT_READY),
    .out_data(EVT_DATA)
  );
endmodule // sdram_cmd_fsm
`default_nettype wire

/* File: pkg/sdram_cmd_pkg.sv */
`default_nettype none
package sdram_cmd_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROW_CYCLE_NS = 60;       // row cycle time
  localparam int PRECHARGE_NS = 20;       // row precharge time
  localparam int WRITE_REC_NS = 20;       // write recovery time
  localparam int RENEW_PERIOD_NS = 32000000;
  localparam int RENEW_ROWS = 2048;
  // least times round up, the renewal interval rounds down
  localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int WRITE_REC_CYC = (WRITE_REC_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int RENEW_TICK_CYC = RENEW_PERIOD_NS /
                                  (RENEW_ROWS * CLK_PERIOD_NS);

  // ------------------------------------------------------------
  // widths, field positions, reset values
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int BANK_SELECT_BIT = 11;
  localparam int AUTOCLOSE_FLAG_BIT = 10;
  localparam int COL_W = 8;
  localparam int ROW_W = 11;
  localparam int MODE_W = 11;
  localparam int CNT_W = 16;
  localparam int EVT_DEPTH = 16;
  localparam logic [MODE_W-1:0] MODE_RESET = 11'h000;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_UNSELECTED = 4'h0, CMD_IDLE = 4'h1, CMD_HALT = 4'h2,
    CMD_FETCH = 4'h3, CMD_STORE = 4'h4, CMD_ROW_OPEN = 4'h5,
    CMD_CLOSE = 4'h6, CMD_RENEW = 4'h7, CMD_MODE_LOAD = 4'h8
  } cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ROW_ACTIVE = 4'h1, ST_READ = 4'h2,
    ST_WRITE = 4'h3, ST_READ_AC = 4'h4, ST_WRITE_REC = 4'h5,
    ST_PRECHARGE = 4'h6, ST_REFRESH = 4'h7, ST_SELF_RENEW = 4'h8,
    ST_LOW_POWER = 4'h9
  } st_e;

  typedef struct packed {
    cmd_e kind;
    logic bank;
    logic [COL_W-1:0] col;
  } evt_s;

  // strobe decode, all strobes active low
  function automatic cmd_e decode(input logic cs_n, input logic ras_n,
                                  input logic cas_n, input logic we_n);
    if (cs_n)
      return CMD_UNSELECTED;
    unique case ({ras_n, cas_n, we_n})
      3'h7: return CMD_IDLE;
      3'h6: return CMD_HALT;
      3'h5: return CMD_FETCH;
      3'h4: return CMD_STORE;
      3'h3: return CMD_ROW_OPEN;
      3'h2: return CMD_CLOSE;
      3'h1: return CMD_RENEW;
      default: return CMD_MODE_LOAD;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: tb/sdram_cmd_fsm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module sdram_cmd_fsm_chk
  import sdram_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire st_e STATE,
  input wire logic SUSPENDED,
  input wire logic ILLEGAL_CMD,
  input wire logic [COL_W-1:0] COLUMN,
  input wire logic HOLD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // deselect or no-operation on the strobes
  wire logic quiet = CS_N || (RAS_N && CAS_N && WE_N);
  // clock enable falling in a burst or in idle
  sequence s_burst_fall;
    (STATE inside {ST_READ, ST_WRITE}) && $past(CKE) && !CKE && !HOLD;
  endsequence
  sequence s_idle_fall;
    STATE == ST_IDLE && $past(CKE) && !CKE && quiet && !HOLD;
  endsequence
  sequence s_fetch;
    STATE == ST_ROW_ACTIVE && CKE && $past(CKE) && !HOLD && !CS_N &&
      RAS_N && !CAS_N && WE_N;
  endsequence
  a_hold_entry: assert property (s_burst_fall |=>
    SUSPENDED && STATE == $past(STATE)) else $error("suspend entry");
  a_hold_frozen: assert property (SUSPENDED && !CKE |=>
    $stable(STATE)) else $error("suspend not frozen");
  a_hold_exit: assert property (SUSPENDED && CKE |=>
    !SUSPENDED) else $error("suspend exit");
  a_idle_powerdown: assert property (s_idle_fall |=>
    STATE == ST_LOW_POWER) else $error("power-down entry");
  a_lowpower_exit: assert property (STATE == ST_LOW_POWER && CKE |=>
    STATE == ST_IDLE) else $error("power-down exit");
  a_renew_stay: assert property (STATE == ST_SELF_RENEW && !CKE |=>
    STATE == ST_SELF_RENEW) else $error("self-renewal left");
  a_renew_exit: assert property (STATE == ST_SELF_RENEW && CKE && quiet
    |=> STATE == ST_REFRESH) else $error("self-renewal exit");
  a_fetch_column: assert property (s_fetch |=>
    STATE == ($past(ADDR[AUTOCLOSE_FLAG_BIT]) ? ST_READ_AC : ST_READ) &&
    COLUMN == $past(ADDR[COL_W-1:0])) else $error("read start");
  a_autoclose_only: assert property (STATE == ST_READ_AC && CKE &&
    $past(CKE) && !quiet && !HOLD |=> ILLEGAL_CMD)
    else $error("autoclose command accepted");
  a_illegal_keeps: assert property (ILLEGAL_CMD &&
    $past(STATE) != ST_READ_AC |-> $stable(STATE))
    else $error("illegal command moved state");
endmodule // sdram_cmd_fsm_chk

bind sdram_cmd_fsm sdram_cmd_fsm_chk sdram_cmd_fsm_chk_inst (.CLK, .NRST,
  .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N, .ADDR, .STATE, .SUSPENDED,
  .ILLEGAL_CMD, .COLUMN, .HOLD);
`default_nettype wire

/* File: tb/sdram_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// memory controller model
// ------------------------------------------------------------
module sdram_ctrl_model
  import sdram_cmd_pkg::*;
(
  output logic CKE = 1'b1, // pins idle until the first command
  output logic CS_N = 1'b1,
  output logic RAS_N = 1'b1,
  output logic CAS_N = 1'b1,
  output logic WE_N = 1'b1,
  output logic [ADDR_W-1:0] ADDR = 12'h000
);
  // one command, strobes active low; deselect scrambles the rest
  task automatic issue(input cmd_e c, input logic k,
                       input logic [ADDR_W-1:0] a);
    CKE = k;
    CS_N = (c == CMD_UNSELECTED);
    if (c == CMD_UNSELECTED) begin
      {RAS_N, CAS_N, WE_N} = ~{RAS_N, CAS_N, WE_N};
      ADDR = ~ADDR;
    end else begin
      {RAS_N, CAS_N, WE_N} = 3'(4'h8 - c);
      ADDR = a;
    end
  endtask
endmodule // sdram_ctrl_model
`default_nettype wire

/* File: tb/sdram_cmd_fsm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// testbench
// ------------------------------------------------------------
module sdram_cmd_fsm_tb
  import sdram_cmd_pkg::*;
;
  logic CLK, NRST, fill;
  logic EVT_READY = 1'b0;
  wire logic CKE, CS_N, RAS_N, CAS_N, WE_N;
  wire logic [ADDR_W-1:0] ADDR;
  logic EVT_VALID, SUSPENDED, ILLEGAL_CMD, BURST_BANK, HOLD;
  evt_s EVT_DATA;
  st_e STATE;
  logic [1:0] OPEN_BANKS;
  logic [COL_W-1:0] COLUMN, c1, c2;
  logic [MODE_W-1:0] MODE_WORD;
  logic [ROW_W-1:0] RENEW_ROW, r0;
  logic [ADDR_W-1:0] a;
  logic [31:0] lfsr = 32'hd9630455;
  int fails = 0;
  int n_tests = 0;
  evt_s expq[$];
  cmd_e bad_id[2] = '{CMD_FETCH, CMD_STORE};
  cmd_e bad_ra[3] = '{CMD_ROW_OPEN, CMD_RENEW, CMD_MODE_LOAD};
  cmd_e p1[6] = '{CMD_FETCH, CMD_FETCH, CMD_FETCH, CMD_STORE, CMD_STORE,
    CMD_STORE};
  cmd_e p2[6] = '{CMD_HALT, CMD_FETCH, CMD_STORE, CMD_HALT, CMD_FETCH,
    CMD_STORE};
  st_e pe[6] = '{ST_ROW_ACTIVE, ST_READ, ST_WRITE, ST_ROW_ACTIVE, ST_READ,
    ST_WRITE};

  sdram_cmd_fsm sdram_cmd_fsm_inst (.CLK(CLK), .NRST(NRST), .CKE(CKE),
    .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR),
    .EVT_READY(EVT_READY), .EVT_VALID(EVT_VALID), .EVT_DATA(EVT_DATA),
    .STATE(STATE), .OPEN_BANKS(OPEN_BANKS), .SUSPENDED(SUSPENDED),
    .ILLEGAL_CMD(ILLEGAL_CMD), .COLUMN(COLUMN), .BURST_BANK(BURST_BANK),
    .MODE_WORD(MODE_WORD), .RENEW_ROW(RENEW_ROW), .HOLD(HOLD));
  sdram_ctrl_model sdram_ctrl_model_inst (.CKE(CKE), .CS_N(CS_N),
    .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic close_out();
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic go(input cmd_e c, input logic k, input logic [11:0] ad);
    @(negedge CLK);
    sdram_ctrl_model_inst.issue(c, k, ad);
    @(posedge CLK);
    // event word taken at this edge, read before it updates
    if (EVT_VALID === 1'b1 && EVT_READY === 1'b1 && expq.size() > 0) begin
      chk("evt kind", 16'(EVT_DATA.kind), 16'(expq[0].kind));
      chk("evt bank", 16'(EVT_DATA.bank), 16'(expq[0].bank));
      chk("evt col", 16'(EVT_DATA.col), 16'(expq[0].col));
      void'(expq.pop_front());
    end
    #1;
  endtask

  task automatic step(input cmd_e c, input logic k, input logic [11:0] ad,
                      input st_e e);
    go(c, k, ad);
    chk("state", 16'(STATE), 16'(e));
  endtask

  task automatic bad(input cmd_e c, input st_e e);
    step(c, 1'b1, 12'h000, e);
    chk("illegal", 16'(ILLEGAL_CMD), 16'h1);
  endtask

  task automatic wait_st(input st_e e, input int n);
    for (int i = 0; i < n && STATE !== e; i++)
      go(CMD_IDLE, 1'b1, 12'h000);
    if (STATE !== e) begin
      chk("state wait", 16'(STATE), 16'(e)); // time limit used up
      close_out();
    end
  endtask

  // clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // random consumer readiness, held low while filling
  always @(negedge CLK) begin
    lfsr <= nxt(lfsr);
    EVT_READY <= !fill && lfsr[1:0] != 2'h0;
  end

  // main sequence
  initial begin
    NRST = 1'b0;
    fill = 1'b0;
    repeat (4) @(posedge CLK);
    @(negedge CLK) NRST = 1'b1;
    repeat (4) @(posedge CLK);
    #1 chk("rst state", 16'(STATE), 16'(ST_IDLE));
    chk("rst mode", 16'(MODE_WORD), 16'(MODE_RESET));
    expq.push_back('{CMD_MODE_LOAD, 1'b0, 8'h01});
    step(CMD_MODE_LOAD, 1'b1, 12'h001, ST_IDLE);
    chk("mode", 16'(MODE_WORD), 16'h001);
    repeat (8) go(CMD_IDLE, 1'b1, 12'h000);
    fill = 1'b1;
    repeat (3) go(CMD_UNSELECTED, 1'b1, 12'h000);
    for (int i = 0; i < 17; i++) begin
      a = {lfsr[0], 11'h000};
      expq.push_back('{CMD_CLOSE, a[11], 8'h00});
      go(CMD_CLOSE, 1'b1, a);
    end
    repeat (4) go(CMD_IDLE, 1'b1, 12'h000);
    chk("hold", 16'(HOLD), 16'h1);
    fill = 1'b0;
    for (int i = 0; i < 200 && expq.size() > 0; i++)
      go(CMD_IDLE, 1'b1, 12'h000);
    chk("drained", 16'(expq.size()), 16'h0);
    foreach (bad_id[i]) bad(bad_id[i], ST_IDLE);
    for (int i = 0; i < 2; i++) begin
      step(i ? CMD_IDLE : CMD_UNSELECTED, 1'b0, 12'h000, ST_LOW_POWER);
      step(CMD_IDLE, 1'b0, 12'h000, ST_LOW_POWER);
      step(CMD_STORE, 1'b1, 12'h000, ST_IDLE);
    end
    step(CMD_RENEW, 1'b0, 12'h000, ST_SELF_RENEW);
    r0 = RENEW_ROW;
    step(CMD_IDLE, 1'b0, 12'h000, ST_SELF_RENEW);
    repeat (RENEW_TICK_CYC - 2) go(CMD_IDLE, 1'b0, 12'h000);
    chk("renew row", 16'(RENEW_ROW), 16'(r0));
    go(CMD_IDLE, 1'b0, 12'h000);
    chk("renew row", 16'(RENEW_ROW), 16'(ROW_W'(r0 + 1'b1)));
    step(CMD_UNSELECTED, 1'b1, 12'h000, ST_REFRESH);
    wait_st(ST_IDLE, 10);
    // plain refresh from idle: one row, row cycle time long
    r0 = RENEW_ROW;
    step(CMD_RENEW, 1'b1, 12'h000, ST_REFRESH);
    chk("refresh row", 16'(RENEW_ROW), 16'(ROW_W'(r0 + 1'b1)));
    repeat (ROW_CYCLE_CYC - 1) go(CMD_IDLE, 1'b1, 12'h000);
    chk("refresh len", 16'(STATE), 16'(ST_REFRESH));
    step(CMD_IDLE, 1'b1, 12'h000, ST_IDLE);
    step(CMD_ROW_OPEN, 1'b1, 12'h000, ST_ROW_ACTIVE);
    chk("open", 16'(OPEN_BANKS), 16'h1);
    foreach (bad_ra[i]) bad(bad_ra[i], ST_ROW_ACTIVE);
    step(CMD_FETCH, 1'b1, 12'h000, ST_READ);
    step(CMD_IDLE, 1'b1, 12'h000, ST_READ);
    step(CMD_IDLE, 1'b1, 12'h000, ST_ROW_ACTIVE);
    step(CMD_STORE, 1'b1, 12'h000, ST_WRITE);
    step(CMD_IDLE, 1'b1, 12'h000, ST_WRITE);
    step(CMD_IDLE, 1'b1, 12'h000, ST_WRITE_REC);
    wait_st(ST_ROW_ACTIVE, 6);
    for (int i = 0; i < 6; i++) begin
      c1 = lfsr[7:0];
      c2 = lfsr[15:8];
      step(p1[i], 1'b1, {4'h0, c1}, p1[i] == CMD_FETCH ? ST_READ : ST_WRITE);
      step(p2[i], 1'b1, {4'h0, c2}, pe[i]);
      if (p2[i] != CMD_HALT)
        chk("column", 16'(COLUMN), 16'(c2));
      wait_st(ST_ROW_ACTIVE, 8);
    end
    step(CMD_FETCH, 1'b1, 12'h000, ST_READ);
    step(CMD_FETCH, 1'b0, 12'h0ff, ST_READ);
    chk("suspend", 16'(SUSPENDED), 16'h1);
    chk("column kept", 16'(COLUMN), 16'h0);
    step(CMD_IDLE, 1'b0, 12'h000, ST_READ);
    step(CMD_STORE, 1'b1, 12'h000, ST_READ);
    chk("resume", 16'(SUSPENDED), 16'h0);
    wait_st(ST_ROW_ACTIVE, 8);
    step(CMD_FETCH, 1'b1, 12'h400, ST_READ_AC);
    bad(CMD_HALT, ST_READ_AC);
    wait_st(ST_IDLE, 10);
    chk("autoclose", 16'(OPEN_BANKS), 16'h0);
    for (int i = 0; i < 2; i++) begin
      a = {i[0], 11'h000};
      step(CMD_ROW_OPEN, 1'b1, a, ST_ROW_ACTIVE);
      chk("open bank", 16'(OPEN_BANKS), 16'(i ? 2'h2 : 2'h1));
      step(i ? CMD_STORE : CMD_FETCH, 1'b1, a, i ? ST_WRITE : ST_READ);
      chk("burst bank", 16'(BURST_BANK), 16'(i[0]));
      step(CMD_CLOSE, 1'b1, {1'b0, i[0], 10'h000}, ST_PRECHARGE);
      wait_st(ST_IDLE, 6);
      chk("closed", 16'(OPEN_BANKS), 16'h0);
    end
    close_out();
  end
endmodule // sdram_cmd_fsm_tb
`default_nettype wire
